// ---- pkg/hgc_map.vh ----
`ifndef HGC_MAP_VH
`define HGC_MAP_VH
// Register indices
`define HGC_IDX_MODE   8'h45
`define HGC_IDX_XH     8'h46
`define HGC_IDX_XL     8'h47
`define HGC_IDX_YH     8'h48
`define HGC_IDX_YL     8'h49
`define HGC_IDX_FG     8'h4a
`define HGC_IDX_BG     8'h4b
`define HGC_IDX_STH    8'h4c
`define HGC_IDX_STL    8'h4d
`define HGC_IDX_DX     8'h4e
`define HGC_IDX_DY     8'h4f
// Mode register fields
`define HGC_BIT_ENABLE 0
`define HGC_BIT_FDMSB  1
`define HGC_BIT_RIGHT  4
`define CURSOR_MODE_CONTROL_MASK  8'h13
// Field masks for reserved bits
`define HGC_HI3_MASK   8'h07
`define HGC_HI4_MASK   8'h0f
`define HGC_OFS_MASK   8'h3f
// Reset values and stack pointer codes
`define HGC_RST_BYTE   8'h00
`define HGC_RST_PTR    2'h0
`define HGC_PTR_LAST   2'h2
`define HGC_PTR_FULL   2'h3
// Right storage placement
`define HGC_RS_SEL_MASK 2'h3
`define HGC_RS_LINE4    12'h300
`define HGC_RS_LINE8    12'h600
`endif

// ---- logic/hgc_colour_stack.v ----
`timescale 1ns/1ps
`default_nettype none
`include "hgc_map.vh"
module hgc_colour_stack (
    // Clock and reset
    input  wire        CORE_CLK,
    input  wire        RST,
    // Write side
    input  wire        wr,
    input  wire [1:0]  ptr,
    input  wire [7:0]  wdata,
    // Contents
    output reg  [23:0] colour
);
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            colour <= {3{`HGC_RST_BYTE}};
        end else if (wr) begin
            // Pointer value 3 means the stack is full; writes then fall away
            case (ptr)
                2'h0: colour[7:0]   <= wdata;
                2'h1: colour[15:8]  <= wdata;
                2'h2: colour[23:16] <= wdata;
                default: colour <= colour;
            endcase
        end
    end
endmodule // hgc_colour_stack
`default_nettype wire

// ---- logic/hgc_pos_latch.v ----
`timescale 1ns/1ps
`default_nettype none
`include "hgc_map.vh"
module hgc_pos_latch #(
    parameter W = 11
) (
    // Clock and reset
    input  wire         CORE_CLK,
    input  wire         RST,
    // Staged values and commit
    input  wire         commit,
    input  wire [W-1:0] x_stage,
    input  wire [W-1:0] y_stage,
    // Live position
    output reg  [W-1:0] x_live,
    output reg  [W-1:0] y_live
);
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            x_live <= {W{1'b0}};
            y_live <= {W{1'b0}};
        end else if (commit) begin
            x_live <= x_stage;
            y_live <= y_stage;
        end
    end
endmodule // hgc_pos_latch
`default_nettype wire

// ---- logic/hgc_regs.v ----
`timescale 1ns/1ps
`default_nettype none
`include "hgc_map.vh"
module hgc_regs #(
    parameter CW = 11,
    parameter SW = 12,
    parameter OW = 6
) (
    // Clock and reset
    input  wire          CORE_CLK,
    input  wire          RST,
    // Indexed register port
    input  wire [7:0]    REG_INDEX,
    input  wire          REG_WR,
    input  wire          REG_RD,
    input  wire [7:0]    REG_WDATA,
    output reg  [7:0]    REG_RDATA,
    output wire          REG_HIT,
    // Display context
    input  wire          ENHANCED_MODE,
    input  wire          PIX_8BPP,
    input  wire [2:0]    SEQ_FETCH_DELAY,
    // Cursor controls
    output wire          CURSOR_VISIBLE,
    output wire [3:0]    CURSOR_FETCH_DELAY,
    output wire          CURSOR_RIGHT_STORAGE,
    output wire [CW-1:0] CURSOR_X_ORIGIN,
    output wire [CW-1:0] CURSOR_Y_ORIGIN,
    output wire [SW-1:0] CURSOR_STORAGE_START,
    output reg  [SW-1:0] CURSOR_FETCH_BASE,
    output wire [OW-1:0] PATTERN_X_OFFSET,
    output wire [OW-1:0] PATTERN_Y_OFFSET,
    output wire [23:0]   CURSOR_FG_COLOUR,
    output wire [23:0]   CURSOR_BG_COLOUR
);
    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    reg  [7:0] mode;
    reg  [7:0] x_hi;
    reg  [7:0] x_lo;
    reg  [7:0] y_hi;
    reg  [7:0] y_lo;
    reg  [7:0] st_hi;
    reg  [7:0] st_lo;
    reg  [7:0] dx;
    reg  [7:0] dy;
    reg  [1:0] stk_ptr;
    reg  [1:0] next_stk_ptr;
    wire       wr_mode;
    wire       wr_xh;
    wire       wr_xl;
    wire       wr_yh;
    wire       wr_yl;
    wire       wr_fg;
    wire       wr_bg;
    wire       wr_sth;
    wire       wr_stl;
    wire       wr_dx;
    wire       wr_dy;
    wire       rd_mode;
    wire       commit;

    function hit;
        input [7:0] idx;
        input [7:0] want;
        begin
            hit = (idx == want);
        end
    endfunction

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    // One strobe per index keeps each register's process on its own;
    // an unmapped index raises none of them and is simply ignored.
    assign REG_HIT = (REG_INDEX >= `HGC_IDX_MODE) && (REG_INDEX <= `HGC_IDX_DY);
    assign wr_mode = REG_WR && hit(REG_INDEX, `HGC_IDX_MODE);
    assign wr_xh   = REG_WR && hit(REG_INDEX, `HGC_IDX_XH);
    assign wr_xl   = REG_WR && hit(REG_INDEX, `HGC_IDX_XL);
    assign wr_yh   = REG_WR && hit(REG_INDEX, `HGC_IDX_YH);
    assign wr_yl   = REG_WR && hit(REG_INDEX, `HGC_IDX_YL);
    assign wr_fg   = REG_WR && hit(REG_INDEX, `HGC_IDX_FG);
    assign wr_bg   = REG_WR && hit(REG_INDEX, `HGC_IDX_BG);
    assign wr_sth  = REG_WR && hit(REG_INDEX, `HGC_IDX_STH);
    assign wr_stl  = REG_WR && hit(REG_INDEX, `HGC_IDX_STL);
    assign wr_dx   = REG_WR && hit(REG_INDEX, `HGC_IDX_DX);
    assign wr_dy   = REG_WR && hit(REG_INDEX, `HGC_IDX_DY);
    assign rd_mode = REG_RD && hit(REG_INDEX, `HGC_IDX_MODE);
    assign commit  = wr_yh;

    // Reserved mode bits are dropped on write and read back as zero
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            mode <= `HGC_RST_BYTE;
        end else if (wr_mode) begin
            mode <= REG_WDATA & `CURSOR_MODE_CONTROL_MASK;
        end
    end

    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            x_hi <= `HGC_RST_BYTE;
        end else if (wr_xh) begin
            x_hi <= REG_WDATA & `HGC_HI3_MASK;
        end
    end

    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            x_lo <= `HGC_RST_BYTE;
        end else if (wr_xl) begin
            x_lo <= REG_WDATA;
        end
    end

    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            y_hi <= `HGC_RST_BYTE;
        end else if (wr_yh) begin
            y_hi <= REG_WDATA & `HGC_HI3_MASK;
        end
    end

    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            y_lo <= `HGC_RST_BYTE;
        end else if (wr_yl) begin
            y_lo <= REG_WDATA;
        end
    end

    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            st_hi <= `HGC_RST_BYTE;
        end else if (wr_sth) begin
            st_hi <= REG_WDATA & `HGC_HI4_MASK;
        end
    end

    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            st_lo <= `HGC_RST_BYTE;
        end else if (wr_stl) begin
            st_lo <= REG_WDATA;
        end
    end

    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            dx <= `HGC_RST_BYTE;
        end else if (wr_dx) begin
            dx <= REG_WDATA & `HGC_OFS_MASK;
        end
    end

    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            dy <= `HGC_RST_BYTE;
        end else if (wr_dy) begin
            dy <= REG_WDATA & `HGC_OFS_MASK;
        end
    end

    // ------------------------------------------------------------
    // Shared colour stack pointer
    // ------------------------------------------------------------
    // A mode read in the same cycle as a stack write clears after the
    // write has landed; the clear wins over the increment.
    always @* begin
        next_stk_ptr = stk_ptr;
        if ((wr_fg || wr_bg) && (stk_ptr != `HGC_PTR_FULL)) begin
            next_stk_ptr = stk_ptr + 2'h1;
        end
        if (rd_mode) begin
            next_stk_ptr = `HGC_RST_PTR;
        end
    end

    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            stk_ptr <= `HGC_RST_PTR;
        end else begin
            stk_ptr <= next_stk_ptr;
        end
    end

    hgc_colour_stack u_fg (
        .CORE_CLK (CORE_CLK),
        .RST      (RST),
        .wr       (wr_fg),
        .ptr      (stk_ptr),
        .wdata    (REG_WDATA),
        .colour   (CURSOR_FG_COLOUR)
    );

    hgc_colour_stack u_bg (
        .CORE_CLK (CORE_CLK),
        .RST      (RST),
        .wr       (wr_bg),
        .ptr      (stk_ptr),
        .wdata    (REG_WDATA),
        .colour   (CURSOR_BG_COLOUR)
    );

    // ------------------------------------------------------------
    // Position commit
    // ------------------------------------------------------------
    // Y high is staged via the same write that commits, so feed the
    // incoming byte directly to avoid a one-write lag.
    wire [CW-1:0] x_stage;
    wire [CW-1:0] y_stage;
    assign x_stage = {x_hi[2:0], x_lo};
    assign y_stage = {REG_WDATA[2:0], y_lo};

    hgc_pos_latch #(.W(CW)) u_pos (
        .CORE_CLK (CORE_CLK),
        .RST      (RST),
        .commit   (commit),
        .x_stage  (x_stage),
        .y_stage  (y_stage),
        .x_live   (CURSOR_X_ORIGIN),
        .y_live   (CURSOR_Y_ORIGIN)
    );

    // ------------------------------------------------------------
    // Read back
    // ------------------------------------------------------------
    // Stack reads return the byte at the pointer; a full stack reads the
    // last byte. A stack read does not move the pointer; a mode read clears it.
    reg [7:0] fg_byte;
    reg [7:0] bg_byte;
    always @* begin
        case (stk_ptr)
            2'h0: begin
                fg_byte = CURSOR_FG_COLOUR[7:0];
                bg_byte = CURSOR_BG_COLOUR[7:0];
            end
            2'h1: begin
                fg_byte = CURSOR_FG_COLOUR[15:8];
                bg_byte = CURSOR_BG_COLOUR[15:8];
            end
            default: begin
                fg_byte = CURSOR_FG_COLOUR[23:16];
                bg_byte = CURSOR_BG_COLOUR[23:16];
            end
        endcase
    end

    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            REG_RDATA <= `HGC_RST_BYTE;
        end else if (REG_RD) begin
            if (hit(REG_INDEX, `HGC_IDX_MODE)) begin
                REG_RDATA <= mode;
            end else if (hit(REG_INDEX, `HGC_IDX_XH)) begin
                REG_RDATA <= x_hi;
            end else if (hit(REG_INDEX, `HGC_IDX_XL)) begin
                REG_RDATA <= x_lo;
            end else if (hit(REG_INDEX, `HGC_IDX_YH)) begin
                REG_RDATA <= y_hi;
            end else if (hit(REG_INDEX, `HGC_IDX_YL)) begin
                REG_RDATA <= y_lo;
            end else if (hit(REG_INDEX, `HGC_IDX_FG)) begin
                REG_RDATA <= fg_byte;
            end else if (hit(REG_INDEX, `HGC_IDX_BG)) begin
                REG_RDATA <= bg_byte;
            end else if (hit(REG_INDEX, `HGC_IDX_STH)) begin
                REG_RDATA <= st_hi;
            end else if (hit(REG_INDEX, `HGC_IDX_STL)) begin
                REG_RDATA <= st_lo;
            end else if (hit(REG_INDEX, `HGC_IDX_DX)) begin
                REG_RDATA <= dx;
            end else if (hit(REG_INDEX, `HGC_IDX_DY)) begin
                REG_RDATA <= dy;
            end else begin
                REG_RDATA <= `HGC_RST_BYTE;
            end
        end
    end

    // ------------------------------------------------------------
    // Derived cursor controls
    // ------------------------------------------------------------
    wire          cursor_enable;
    wire          cursor_fetch_delay_msb;
    wire          cursor_right_storage;
    reg  [SW-1:0] next_fetch_base;

    // Mode fields by name, so the outputs below read as the rules do
    assign cursor_enable          = mode[`HGC_BIT_ENABLE];
    assign cursor_fetch_delay_msb = mode[`HGC_BIT_FDMSB];
    assign cursor_right_storage   = mode[`HGC_BIT_RIGHT];

    assign CURSOR_VISIBLE       = cursor_enable && ENHANCED_MODE;
    assign CURSOR_FETCH_DELAY   = {cursor_fetch_delay_msb, SEQ_FETCH_DELAY};
    assign CURSOR_RIGHT_STORAGE = cursor_right_storage;
    assign CURSOR_STORAGE_START = {st_hi[3:0], st_lo};
    assign PATTERN_X_OFFSET     = dx[OW-1:0];
    assign PATTERN_Y_OFFSET     = dy[OW-1:0];

    // ------------------------------------------------------------
    // Fetch base
    // ------------------------------------------------------------
    // Fetch base in 1 KByte units. Right storage ORs in the in-line
    // offset of the tail region; the driver must have set low bits to
    // 11 so the OR lands on the final 256 or 512 bytes.
    always @* begin
        next_fetch_base = CURSOR_STORAGE_START;
        if (cursor_right_storage) begin
            if (PIX_8BPP) begin
                next_fetch_base = CURSOR_STORAGE_START | `HGC_RS_LINE8;
            end else begin
                next_fetch_base = CURSOR_STORAGE_START | `HGC_RS_LINE4;
            end
        end
    end

    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            CURSOR_FETCH_BASE <= {SW{1'b0}};
        end else begin
            CURSOR_FETCH_BASE <= next_fetch_base;
        end
    end
endmodule // hgc_regs
`default_nettype wire

// ---- tb/hgc_regs_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module hgc_regs_chk #(
    parameter CW = 11,
    parameter SW = 12,
    parameter OW = 6
) (
    input wire logic          CORE_CLK,
    input wire logic          RST,
    input wire logic [7:0]    REG_INDEX,
    input wire logic          REG_WR,
    input wire logic          REG_RD,
    input wire logic [7:0]    REG_WDATA,
    input wire logic [7:0]    REG_RDATA,
    input wire logic          REG_HIT,
    input wire logic          ENHANCED_MODE,
    input wire logic          PIX_8BPP,
    input wire logic [2:0]    SEQ_FETCH_DELAY,
    input wire logic          CURSOR_VISIBLE,
    input wire logic [3:0]    CURSOR_FETCH_DELAY,
    input wire logic          CURSOR_RIGHT_STORAGE,
    input wire logic [CW-1:0] CURSOR_X_ORIGIN,
    input wire logic [CW-1:0] CURSOR_Y_ORIGIN,
    input wire logic [SW-1:0] CURSOR_STORAGE_START,
    input wire logic [SW-1:0] CURSOR_FETCH_BASE,
    input wire logic [OW-1:0] PATTERN_X_OFFSET,
    input wire logic [OW-1:0] PATTERN_Y_OFFSET
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    // ----------------------------------------
    // Write decode and derived cursor outputs
    // ----------------------------------------
    sequence s_wr(logic [7:0] i);
        REG_WR && REG_INDEX == i;
    endsequence
    AST_ENB: assert property (s_wr(8'h45) |=>
        CURSOR_VISIBLE == ($past(REG_WDATA[0]) && ENHANCED_MODE)) else $error("enable bit");
    AST_VIS: assert property (CURSOR_VISIBLE |-> ENHANCED_MODE) else $error("visible");
    AST_FD: assert property (s_wr(8'h45) |=>
        CURSOR_FETCH_DELAY == {$past(REG_WDATA[1]), SEQ_FETCH_DELAY}) else $error("delay");
    AST_HOLD: assert property (!(REG_WR && REG_INDEX == 8'h48) |=>
        $stable(CURSOR_X_ORIGIN) && $stable(CURSOR_Y_ORIGIN)) else $error("position moved");
    AST_COMMIT: assert property (s_wr(8'h48) |=>
        CURSOR_Y_ORIGIN[10:8] == $past(REG_WDATA[2:0])) else $error("y high");
    AST_STA: assert property (s_wr(8'h4c) |=>
        CURSOR_STORAGE_START[11:8] == $past(REG_WDATA[3:0])) else $error("start high");
    AST_OFSX: assert property (s_wr(8'h4e) |=>
        PATTERN_X_OFFSET == $past(REG_WDATA[5:0])) else $error("x offset");
    AST_OFSY: assert property (s_wr(8'h4f) |=>
        PATTERN_Y_OFFSET == $past(REG_WDATA[5:0])) else $error("y offset");
    AST_BASE: assert property (1'b1 |=>
        CURSOR_FETCH_BASE == ($past(CURSOR_STORAGE_START) |
        ($past(CURSOR_RIGHT_STORAGE) ? ($past(PIX_8BPP) ? 12'h600 : 12'h300) : 12'h000)))
        else $error("fetch base");
endmodule // hgc_regs_chk
bind hgc_regs hgc_regs_chk #(.CW(CW), .SW(SW), .OW(OW)) u_hgc_regs_chk (
    .CORE_CLK(CORE_CLK), .RST(RST), .REG_INDEX(REG_INDEX), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_HIT(REG_HIT),
    .ENHANCED_MODE(ENHANCED_MODE), .PIX_8BPP(PIX_8BPP), .SEQ_FETCH_DELAY(SEQ_FETCH_DELAY),
    .CURSOR_VISIBLE(CURSOR_VISIBLE), .CURSOR_FETCH_DELAY(CURSOR_FETCH_DELAY),
    .CURSOR_RIGHT_STORAGE(CURSOR_RIGHT_STORAGE), .CURSOR_X_ORIGIN(CURSOR_X_ORIGIN),
    .CURSOR_Y_ORIGIN(CURSOR_Y_ORIGIN), .CURSOR_STORAGE_START(CURSOR_STORAGE_START),
    .CURSOR_FETCH_BASE(CURSOR_FETCH_BASE), .PATTERN_X_OFFSET(PATTERN_X_OFFSET),
    .PATTERN_Y_OFFSET(PATTERN_Y_OFFSET));
`default_nettype wire

// ---- tb/hgc_regs_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module hgc_regs_tb_top;
    logic        clk, rst, wr_s, rd_s, enh, pix8, hit, vis, rs;
    logic [7:0]  idx, wdata, rdata;
    logic [2:0]  seq;
    logic [3:0]  fd;
    logic [10:0] xo, yo;
    logic [11:0] sta, base;
    logic [5:0]  px, py;
    logic [23:0] fg, bg;
    int          miscompares, checks, cycles, i;

    hgc_regs u_hgc_regs (
        .CORE_CLK(clk), .RST(rst), .REG_INDEX(idx), .REG_WR(wr_s), .REG_RD(rd_s),
        .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_HIT(hit), .ENHANCED_MODE(enh),
        .PIX_8BPP(pix8), .SEQ_FETCH_DELAY(seq), .CURSOR_VISIBLE(vis),
        .CURSOR_FETCH_DELAY(fd), .CURSOR_RIGHT_STORAGE(rs), .CURSOR_X_ORIGIN(xo),
        .CURSOR_Y_ORIGIN(yo), .CURSOR_STORAGE_START(sta), .CURSOR_FETCH_BASE(base),
        .PATTERN_X_OFFSET(px), .PATTERN_Y_OFFSET(py), .CURSOR_FG_COLOUR(fg),
        .CURSOR_BG_COLOUR(bg));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Run needs about 90 cycles; the ceiling leaves ample margin
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            report_and_stop();
        end
    end
    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task report_and_stop;
        if (miscompares == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task step;
        @(posedge clk);
        #1;
    endtask
    // Strobe drops one cycle later, so accesses are spaced by an idle cycle
    task wr(input logic [7:0] a, input logic [7:0] d);
        step();
        wr_s = 1'b1;
        idx = a;
        wdata = d;
        step();
        wr_s = 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        step();
        rd_s = 1'b1;
        idx = a;
        step();
        rd_s = 1'b0;
        chk(rdata, exp);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        {wr_s, rd_s, enh, pix8, idx, wdata} = '0;
        seq = 3'h5;
        {miscompares, checks, cycles} = '0;
        rst = 1'b1;
        repeat (5) @(posedge clk);
        #1 rst = 1'b0;
        for (i = 8'h45; i <= 8'h50; i++) rd(i[7:0], 8'h00);
        chk(hit, 1'b0);
        wr(8'h45, 8'hff);
        rd(8'h45, 8'h13);
        chk(rs, 1'b1);
        chk(vis, 1'b0);
        enh = 1'b1;
        step();
        chk(vis, 1'b1);
        chk(fd, 4'hd);
        wr(8'h4c, 8'hf8);
        wr(8'h4d, 8'h23);
        chk(sta, 12'h823);
        step();
        chk(base, 12'hb23);
        pix8 = 1'b1;
        step();
        chk(base, 12'he23);
        wr(8'h47, 8'h34);
        wr(8'h46, 8'hfa);
        wr(8'h49, 8'h56);
        chk(xo, 11'h000);
        chk(yo, 11'h000);
        wr(8'h48, 8'h01);
        chk(xo, 11'h234);
        chk(yo, 11'h156);
        rd(8'h46, 8'h02);
        chk(hit, 1'b1);
        wr(8'h4e, 8'hff);
        wr(8'h4f, 8'hea);
        chk(px, 6'h3f);
        chk(py, 6'h2a);
        rd(8'h45, 8'h13);
        for (i = 1; i < 5; i++) wr(8'h4a, i[7:0] * 8'h11);
        chk(fg, 24'h332211);
        rd(8'h4a, 8'h33);
        rd(8'h45, 8'h13);
        wr(8'h4b, 8'haa);
        wr(8'h4a, 8'h55);
        wr(8'h4b, 8'hcc);
        chk(bg, 24'hcc00aa);
        chk(fg, 24'h335511);
        rd(8'h45, 8'h13);
        wr(8'h4b, 8'hbb);
        chk(bg, 24'hcc00bb);
        rd(8'h4a, 8'h55);
        wr(8'h45, 8'h01);
        step();
        chk(base, 12'h823);
        chk(rs, 1'b0);
        enh = 1'b0;
        #1;
        chk(vis, 1'b0);
        // Mid-run reset: all back to zero, and enable off hides the cursor
        step();
        rst = 1'b1;
        enh = 1'b1;
        step();
        chk(xo, 11'h000);
        chk(fg, 24'h000000);
        chk(base, 12'h000);
        chk(vis, 1'b0);
        rst = 1'b0;
        rd(8'h4e, 8'h00);
        report_and_stop();
    end
endmodule // hgc_regs_tb_top
`default_nettype wire
